/* design/ccf_cfg.svh */
/*
 * Fetch block constants: field positions, codes, timings.
 * Assumes a 20 MHz clock.
 */
`ifndef CCF_CFG_SVH
`define CCF_CFG_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CCF_CLK_NS        50
`define CCF_XFER_GATE_NS  350
`define CCF_CYC_OVER_NS   150
`define CCF_XFER_CYC      ((`CCF_XFER_GATE_NS + `CCF_CLK_NS - 1) / `CCF_CLK_NS)
`define CCF_OVER_CYC      ((`CCF_CYC_OVER_NS + `CCF_CLK_NS - 1) / `CCF_CLK_NS)

// ----------------------------------------
// Control word field positions (bit 0 is the msb)
// ----------------------------------------
`define CCF_BIT(n)        (63 - (n))
`define CCF_STATUS_ADDR   24'h000040
`define CCF_CC_ACCEPT     2'h0
`define CCF_CC_STATUS     2'h1
`define CCF_CC_NOSEL      2'h3
`define CCF_OP_IDLE       2'h0
`define CCF_OP_WRITE      2'h1
`define CCF_OP_READ       2'h2
`define CCF_OP_RDBACK     2'h3
`define CCF_UNIT_HIGH     4'h0

`endif

/* design/ccf_pkg.sv */
/*
 * Fetch block types.
 * Assumes numbers sit in ccf_cfg.svh.
 */
package ccf_pkg;
    typedef enum logic [6:0] {
        CCF_IDLE  = 7'h01,
        CCF_REQ   = 7'h02,
        CCF_ACC   = 7'h04,
        CCF_LATE  = 7'h08,
        CCF_XFER  = 7'h10,
        CCF_OVER  = 7'h20,
        CCF_FORM  = 7'h40
    } ccf_fetch_t;

    typedef enum logic [5:0] {
        CCF_SS_IDLE = 6'h01,
        CCF_SS_SEL  = 6'h02,
        CCF_SS_ADDR = 6'h04,
        CCF_SS_CHK  = 6'h08,
        CCF_SS_WAIT = 6'h10,
        CCF_SS_DONE = 6'h20
    } ccf_sub_t;
endpackage : ccf_pkg

/* design/ccf_sub_if.sv */
/*
 * Main to subchannel hand-over.
 * Assumes one clock.
 */
`timescale 1ns/1ps
interface ccf_sub_if;
    logic       command_gate;
    logic [7:0] command_byte;
    logic [2:0] end_count;
    logic [2:0] init_bytes;
    logic [2:0] flags;
    logic       last_word;
    logic       dbl_last_word;
    logic       accept;
    logic       no_selection;
    logic       status_cycle;
    logic       busy;

    modport main (output command_gate, command_byte, end_count, init_bytes,
                  flags, last_word, dbl_last_word,
                  input  accept, no_selection, status_cycle, busy);
    modport sub  (input  command_gate, command_byte, end_count, init_bytes,
                  flags, last_word, dbl_last_word,
                  output accept, no_selection, status_cycle, busy);
endinterface : ccf_sub_if

/* design/ccf_subchannel.sv */
/*
 * Selector subchannel initial selection.
 * Assumes tags synchronised by the top.
 */
`timescale 1ns/1ps
`include "ccf_cfg.svh"
module ccf_subchannel
    import ccf_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Selection from main channel
    input  wire logic       select_i,
    input  wire logic [4:0] unit_low_i,
    // I/O interface tags (synchronised)
    input  wire logic       oper_in_i,
    input  wire logic       addr_in_i,
    input  wire logic       sel_in_i,
    input  wire logic [8:0] bus_in_i,
    input  wire logic       status_in_i,
    // I/O interface drive
    output logic       [8:0] bus_out_o,
    output logic             addr_out_o,
    output logic             sel_out_o,
    output logic             disconnect_o,
    // Hand-over
    ccf_sub_if.sub           hs
);
    typedef struct packed {
        ccf_sub_t   st;
        logic [8:0] unit_addr;
        logic       busy;
        logic       init_sel;
        logic       addr_out;
        logic       sel_out;
        logic       disconnect;
        logic       cmd_loaded;
        logic       accept;
        logic       no_sel;
        logic       status_cycle;
        logic [8:0] bus_out;
    } ss_t;

    ss_t s, next_s;

    // ----------------------------------------
    // Selection sequence
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.accept = 1'b0;
        next_s.no_sel = 1'b0;
        next_s.status_cycle = 1'b0;
        if (hs.command_gate) begin
            next_s.cmd_loaded = 1'b1;
        end
        case (s.st)
            CCF_SS_IDLE: begin
                // (R20) busy refuses selects
                if (select_i && !s.busy) begin
                    // (R19) reset, load address
                    next_s = '0;
                    // Parity rides in the top bit
                    next_s.unit_addr = {unit_low_i[4], `CCF_UNIT_HIGH, unit_low_i[3:0]};
                    next_s.st = CCF_SS_SEL;
                end
            end
            CCF_SS_SEL: begin
                // (R20) first phase sets busy
                next_s.busy = 1'b1;
                next_s.init_sel = 1'b1;
                next_s.st = CCF_SS_ADDR;
            end
            CCF_SS_ADDR: begin
                // (R21) address on bus out
                if (!oper_in_i) begin
                    next_s.bus_out = s.unit_addr;
                end
                next_s.st = CCF_SS_CHK;
            end
            CCF_SS_CHK: begin
                // (R22) odd parity at second phase
                if (!(^s.bus_out)) begin
                    next_s.disconnect = 1'b1;
                    next_s.status_cycle = 1'b1;
                    next_s.st = CCF_SS_DONE;
                end else begin
                    next_s.addr_out = 1'b1;
                    next_s.sel_out = 1'b1;
                    next_s.st = CCF_SS_WAIT;
                end
            end
            CCF_SS_WAIT: begin
                if (sel_in_i && s.sel_out) begin
                    // (R9) select returned, no device
                    next_s.no_sel = 1'b1;
                    next_s.sel_out = 1'b0;
                    next_s.addr_out = 1'b0;
                    next_s.st = CCF_SS_DONE;
                end else if (oper_in_i) begin
                    next_s.addr_out = 1'b0;
                    next_s.bus_out = 9'h000;
                    // (R23) compare returned address
                    if (addr_in_i && s.cmd_loaded) begin
                        if (status_in_i) begin
                            // (R10) nonzero status reported
                            if (bus_in_i[7:0] != 8'h00) begin
                                next_s.status_cycle = 1'b1;
                            end else begin
                                next_s.accept = 1'b1;
                            end
                            next_s.st = CCF_SS_DONE;
                        end else if (bus_in_i != s.unit_addr || !(^bus_in_i)) begin
                            next_s.status_cycle = 1'b1;
                            next_s.st = CCF_SS_DONE;
                        end
                    end
                end
            end
            CCF_SS_DONE: begin
                next_s.sel_out = 1'b0;
                next_s.addr_out = 1'b0;
                next_s.init_sel = 1'b0;
                next_s.busy = 1'b0;
                next_s.st = CCF_SS_IDLE;
            end
            default: begin
                next_s.st = CCF_SS_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '{st: CCF_SS_IDLE, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign bus_out_o       = s.bus_out;
    assign addr_out_o      = s.addr_out;
    assign sel_out_o       = s.sel_out;
    assign disconnect_o    = s.disconnect;
    assign hs.accept       = s.accept;
    assign hs.no_selection = s.no_sel;
    assign hs.status_cycle = s.status_cycle;
    assign hs.busy         = s.busy;
endmodule : ccf_subchannel

/* design/ccf_channel.sv */
/*
 * Main channel command fetch and hand-over.
 * Assumes the arbiter runs on clk_i;
 * device tags are async.
 */
// How it works
// (R1) Load command address, raise storage request
// (R2) On response present address, address valid
// (R3) Accept sets latch, withdraws request
// (R4) Advance clears latch, captures data word
// (R5) Late advance, 350ns gate, 150ns cycle over
// (R6) Storage error sets selection check
// (R7) Clean finish sets in-channel, clears required
// (R8) Subchannel accept releases with code 00
// (R9) Select in returned gives code 11
// (R10) Status cycle stores word at 64, code 01
// (R11) Encode command into bits 6 and 7
// (R12) Keep protect key in bits 0-3
// (R13) Complement low address for read backward
// (R14) Add low address to count, overflow bits
// (R15) Prefix bits into bits 37 and 38
// (R16) Count 9-16 double last, 1-8 last
// (R17) Command gate hands fields to subchannel
// (R18) Ending trigger resets main channel
// (R19) Selected subchannel resets, loads unit address
// (R20) First phase sets busy, refuses selects
// (R21) Unit address on bus out
// (R22) Parity check, disconnect, status cycle
// (R23) Device answers, address compared
`timescale 1ns/1ps
`include "ccf_cfg.svh"
module ccf_channel
    import ccf_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Start from processor side
    input  wire logic        start_i,
    input  wire logic [31:0] command_address_word_i,
    input  wire logic        cu_attached_i,
    input  wire logic [1:0]  prefix_i,
    input  wire logic [4:0]  unit_low_i,
    // Storage arbiter
    input  wire logic        arb_response_i,
    input  wire logic        arb_accept_i,
    input  wire logic        arb_advance_i,
    input  wire logic        arb_error_i,
    input  wire logic [63:0] storage_data_out_bus_i,
    output logic             storage_request_o,
    output logic             address_valid_o,
    output logic [23:0]      storage_address_register_o,
    output logic             status_store_o,
    output logic [63:0]      status_word_o,
    // Processor release
    output logic             release_o,
    output logic [1:0]       cond_code_o,
    output logic             sel_check_o,
    output logic             command_required_o,
    output logic [63:0]      control_word_o,
    // I/O interface
    input  wire logic        oper_in_i,
    input  wire logic        addr_in_i,
    input  wire logic        sel_in_i,
    input  wire logic        status_in_i,
    input  wire logic [8:0]  bus_in_i,
    output logic [8:0]       bus_out_o,
    output logic             addr_out_o,
    output logic             sel_out_o,
    output logic             disconnect_o
);
    localparam logic [3:0] XFER_N = 4'(`CCF_XFER_CYC);
    localparam logic [3:0] OVER_N = 4'(`CCF_OVER_CYC);

    typedef struct packed {
        ccf_fetch_t  st;
        logic        cmd_required;
        logic        req;
        logic        addr_valid;
        logic        accept_latch;
        logic        in_dreg;
        logic        in_channel;
        logic        sel_check;
        logic        err;
        logic [3:0]  tmr;
        logic [23:0] sar;
        logic [63:0] dreg;
        logic [63:0] creg;
        logic [7:0]  key;
        logic [2:0]  dab;
        logic        gate;
        logic        last;
        logic        dbl_last;
        logic        ending;
        logic        select;
        logic        release_p;
        logic [1:0]  cc;
        logic        stat_store;
        logic [63:0] stat_word;
        logic [2:0]  s1_oi;
        logic [2:0]  s2_oi;
        logic [8:0]  s1_bi;
        logic [8:0]  s2_bi;
    } ch_t;

    ch_t r, next_r;
    ccf_sub_if hs ();

    logic [8:0] sub_bus_out;
    logic       sub_addr_out;
    logic       sub_sel_out;
    logic       sub_disc;
    logic       status_meta;
    logic       status_sync;

    // ----------------------------------------
    // Subchannel
    // ----------------------------------------
    ccf_subchannel u_sub (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .select_i     (r.select),
        .unit_low_i   (unit_low_i),
        .oper_in_i    (r.s2_oi[0]),
        .addr_in_i    (r.s2_oi[1]),
        .sel_in_i     (r.s2_oi[2]),
        .bus_in_i     (r.s2_bi),
        .status_in_i  (status_sync),
        .bus_out_o    (sub_bus_out),
        .addr_out_o   (sub_addr_out),
        .sel_out_o    (sub_sel_out),
        .disconnect_o (sub_disc),
        .hs           (hs.sub)
    );

    // Status tag synchroniser

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_meta <= 1'b0;
            status_sync <= 1'b0;
        end else begin
            status_meta <= status_in_i;
            status_sync <= status_meta;
        end
    end

    // ----------------------------------------
    // Fetch and control word formation
    // ----------------------------------------
    logic [1:0]  op_code;
    logic [2:0]  dab_fix;
    logic [16:0] sum;
    logic [63:0] cw;
    always_comb begin
        next_r = r;
        next_r.s1_oi = {sel_in_i, addr_in_i, oper_in_i};
        next_r.s2_oi = r.s1_oi;
        next_r.s1_bi = bus_in_i;
        next_r.s2_bi = r.s1_bi;
        next_r.gate = 1'b0;
        next_r.release_p = 1'b0;
        next_r.stat_store = 1'b0;
        next_r.ending = 1'b0;
        next_r.select = 1'b0;
        // (R11) Command code from op byte
        if (r.dreg[59:56] == 4'hC) begin
            op_code = `CCF_OP_RDBACK;
        end else if (r.dreg[56]) begin
            op_code = `CCF_OP_WRITE;
        end else if (r.dreg[57]) begin
            op_code = `CCF_OP_READ;
        end else begin
            op_code = `CCF_OP_IDLE;
        end
        // (R13) Complement for read backward
        dab_fix = (op_code == `CCF_OP_RDBACK) ? ~r.dreg[34:32] : r.dreg[34:32];
        // (R14) Count plus low address
        sum = {1'b0, r.dreg[15:0]} + {14'h0000, dab_fix};
        cw = r.dreg;
        // (R12) Keep protect key
        cw[63:60] = r.key[7:4];
        cw[`CCF_BIT(6)] = op_code[1];
        cw[`CCF_BIT(7)] = op_code[0];
        cw[34:32] = dab_fix;
        cw[15:0] = sum[15:0];
        if (sum[16]) begin
            cw[`CCF_BIT(47)] = 1'b1;
            cw[`CCF_BIT(46)] = 1'b1;
        end
        // (R15) Prefix bits via control unit
        if (cu_attached_i) begin
            cw[`CCF_BIT(37)] = prefix_i[1];
            cw[`CCF_BIT(38)] = prefix_i[0];
        end
        case (r.st)
            CCF_IDLE: begin
                if (start_i && !hs.busy) begin
                    // (R1) Address in, request up
                    next_r.sar = command_address_word_i[23:0];
                    next_r.key = command_address_word_i[31:24];
                    next_r.cmd_required = 1'b1;
                    next_r.in_channel = 1'b0;
                    next_r.sel_check = 1'b0;
                    next_r.err = 1'b0;
                    next_r.req = 1'b1;
                    next_r.select = 1'b1;
                    next_r.st = CCF_REQ;
                end
            end
            CCF_REQ: begin
                // (R2) Present address on response
                if (arb_response_i) begin
                    next_r.addr_valid = 1'b1;
                end
                if (arb_accept_i && r.addr_valid) begin
                    // (R3) Accept latch drops request
                    next_r.accept_latch = 1'b1;
                    next_r.req = 1'b0;
                    next_r.addr_valid = 1'b0;
                    next_r.st = CCF_ACC;
                end
            end
            CCF_ACC: begin
                if (arb_error_i) begin
                    next_r.err = 1'b1;
                end
                // (R4) Advance captures the word
                if (arb_advance_i) begin
                    next_r.accept_latch = 1'b0;
                    next_r.dreg = storage_data_out_bus_i;
                    next_r.st = CCF_LATE;
                end
            end
            CCF_LATE: begin
                // (R5) Late advance marks word held
                next_r.in_dreg = 1'b1;
                next_r.tmr = XFER_N;
                next_r.st = CCF_XFER;
            end
            CCF_XFER: begin
                // (R5) Transfer gate period
                next_r.tmr = r.tmr - 4'h1;
                if (r.tmr == 4'h1) begin
                    next_r.creg = cw;
                    next_r.dab = dab_fix;
                    next_r.in_dreg = 1'b0;
                    next_r.tmr = OVER_N;
                    next_r.st = CCF_OVER;
                end
            end
            CCF_OVER: begin
                next_r.tmr = r.tmr - 4'h1;
                if (r.tmr == 4'h1) begin
                    if (r.err) begin
                        // (R6) Selection sequence check
                        next_r.sel_check = 1'b1;
                        next_r.ending = 1'b1;
                        next_r.st = CCF_IDLE;
                    end else begin
                        // (R7) Word in channel
                        next_r.in_channel = 1'b1;
                        next_r.cmd_required = 1'b0;
                        next_r.st = CCF_FORM;
                    end
                end
            end
            CCF_FORM: begin
                // (R16) Short count flags
                next_r.dbl_last = (r.creg[15:0] >= 16'h0009) &&
                                  (r.creg[15:0] <= 16'h0010);
                next_r.last = (r.creg[15:0] >= 16'h0001) &&
                              (r.creg[15:0] <= 16'h0008);
                // (R17) Command gate out
                next_r.gate = 1'b1;
                // (R18) Ending trigger frees channel
                next_r.ending = 1'b1;
                next_r.st = CCF_IDLE;
            end
            default: begin
                next_r.st = CCF_IDLE;
            end
        endcase
        if (hs.accept) begin
            // (R8) Release with code 00
            next_r.release_p = 1'b1;
            next_r.cc = `CCF_CC_ACCEPT;
        end else if (hs.no_selection) begin
            // (R9) Release with code 11
            next_r.release_p = 1'b1;
            next_r.cc = `CCF_CC_NOSEL;
        end else if (hs.status_cycle || (r.ending && r.sel_check)) begin
            // (R10) Status word to storage
            next_r.stat_store = 1'b1;
            next_r.stat_word = {r.key, r.sar, 8'h00, r.s2_bi[7:0], 16'h0000};
            next_r.release_p = 1'b1;
            next_r.cc = `CCF_CC_STATUS;
        end
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '{st: CCF_IDLE, default: '0};
        end else begin
            r <= next_r;
        end
    end

    // Hand-over wires from registers
    assign hs.command_gate  = r.gate;
    assign hs.command_byte  = r.dreg[63:56];
    assign hs.end_count     = r.creg[2:0];
    assign hs.init_bytes    = r.dab;
    assign hs.flags         = r.creg[`CCF_BIT(32):`CCF_BIT(34)];
    assign hs.last_word     = r.last;
    assign hs.dbl_last_word = r.dbl_last;

    // Output flops
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_out_o    <= 9'h000;
            addr_out_o   <= 1'b0;
            sel_out_o    <= 1'b0;
            disconnect_o <= 1'b0;
        end else begin
            bus_out_o    <= sub_bus_out;
            addr_out_o   <= sub_addr_out;
            sel_out_o    <= sub_sel_out;
            disconnect_o <= sub_disc;
        end
    end

    assign storage_request_o          = r.req;
    assign address_valid_o            = r.addr_valid;
    assign storage_address_register_o = r.stat_store ? `CCF_STATUS_ADDR : r.sar;
    assign status_store_o             = r.stat_store;
    assign status_word_o              = r.stat_word;
    assign release_o                  = r.release_p;
    assign cond_code_o                = r.cc;
    assign sel_check_o                = r.sel_check;
    assign command_required_o         = r.cmd_required;
    assign control_word_o             = r.creg;
endmodule : ccf_channel

/* dv/ccf_channel_props.sv */
/* Checker on the fetch block ports.
   Assumes one clock, high reset. */
`timescale 1ns/1ps
`include "ccf_cfg.svh"
module ccf_channel_props (
    input logic        clk_i,
    input logic        rst_i,
    input logic [31:0] command_address_word_i,
    input logic        arb_response_i,
    input logic        arb_accept_i,
    input logic        arb_advance_i,
    input logic        sel_in_i,
    input logic        storage_request_o,
    input logic        address_valid_o,
    input logic [23:0] storage_address_register_o,
    input logic        status_store_o,
    input logic        release_o,
    input logic [1:0]  cond_code_o,
    input logic        sel_check_o,
    input logic        command_required_o,
    input logic        sel_out_o,
    input logic        addr_out_o,
    input logic [8:0]  bus_out_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_req_addr;
        $rose(storage_request_o) |-> storage_address_register_o == command_address_word_i[23:0];
    endproperty
    a_req_addr: assert property (p_req_addr) else $error("request without address");
    property p_av;
        storage_request_o && arb_response_i |=> address_valid_o;
    endproperty
    a_av: assert property (p_av) else $error("no address valid");
    property p_drop;
        storage_request_o && address_valid_o && arb_accept_i |=> !storage_request_o;
    endproperty
    a_drop: assert property (p_drop) else $error("request held after accept");
    // Fetch end timing
    property p_timing;
        arb_advance_i && command_required_o |=> (command_required_o && !sel_check_o)[*8]
            ##[1:5] (!command_required_o || sel_check_o);
    endproperty
    a_timing: assert property (p_timing) else $error("fetch end timing");
    property p_selchk;
        $rose(sel_check_o) |-> ##[0:60] release_o && cond_code_o == `CCF_CC_STATUS;
    endproperty
    a_selchk: assert property (p_selchk) else $error("check without release");
    property p_nosel;
        sel_out_o && $rose(sel_in_i) |-> ##[2:40] release_o && cond_code_o == `CCF_CC_NOSEL;
    endproperty
    a_nosel: assert property (p_nosel) else $error("no selection code");
    property p_st64;
        status_store_o |-> storage_address_register_o == `CCF_STATUS_ADDR;
    endproperty
    a_st64: assert property (p_st64) else $error("status word address");
    property p_parity;
        addr_out_o |-> ^bus_out_o;
    endproperty
    a_parity: assert property (p_parity) else $error("unit address parity");
    c_acc: cover property (release_o && cond_code_o == `CCF_CC_ACCEPT);
    c_nosel: cover property (release_o && cond_code_o == `CCF_CC_NOSEL);
    c_store: cover property (status_store_o);
endmodule : ccf_channel_props
bind ccf_channel ccf_channel_props u_props (.*);

/* dv/ccf_far_model.sv */
/* Arbiter and one control unit.
   Assumes the channel clock; drives after rising edges. */
`timescale 1ns/1ps
module ccf_far_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       req_i,
    input  wire logic       av_i,
    input  wire logic       sel_out_i,
    input  wire logic       addr_out_i,
    input  wire logic       dev_i,
    input  wire logic [8:0] ua_i,
    input  wire logic [8:0] st_i,
    output logic            resp_o,
    output logic            acc_o,
    output logic            adv_o,
    output logic            oper_o,
    output logic            ain_o,
    output logic            sin_o,
    output logic            stat_o,
    output logic [8:0]      bus_o
);
    logic [5:0] wait_cnt;
    // Released bus toggles so a stale value never passes
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            {resp_o, acc_o, adv_o, oper_o, ain_o, sin_o, stat_o} <= 7'h00;
            bus_o    <= 9'h000;
            wait_cnt <= 6'h00;
        end else begin
            resp_o   <= req_i && !av_i && !resp_o;
            acc_o    <= req_i && av_i && !acc_o;
            adv_o    <= acc_o;
            oper_o   <= dev_i && (sel_out_i || oper_o);
            ain_o    <= oper_o && !addr_out_i;
            sin_o    <= !dev_i && sel_out_i;
            wait_cnt <= ain_o ? wait_cnt + {5'h00, wait_cnt != 6'h3F} : 6'h00;
            stat_o   <= wait_cnt >= 6'h28;
            bus_o    <= (wait_cnt >= 6'h28) ? st_i : ((oper_o && !addr_out_i) ? ua_i : ~bus_o);
        end
    end
endmodule : ccf_far_model

/* dv/ccf_channel_tb.sv */
/* Self-checking bench for the fetch block.
   Assumes the far model answers. */
`timescale 1ns/1ps
module ccf_channel_tb;
    logic clk_i = 1'b0, rst_i = 1'b1, start_i = 1'b0, cu_attached_i = 1'b0;
    logic arb_error_i = 1'b0, dev = 1'b0;
    logic arb_response_i, arb_accept_i, arb_advance_i, storage_request_o, address_valid_o;
    logic status_store_o, release_o, sel_check_o, command_required_o;
    logic oper_in_i, addr_in_i, sel_in_i, status_in_i, addr_out_o, sel_out_o, disconnect_o;
    logic [1:0]  prefix_i = 2'h0, cond_code_o;
    logic [4:0]  unit_low_i = 5'h15;
    logic [8:0]  bus_in_i, bus_out_o, status = 9'h100;
    logic [23:0] storage_address_register_o;
    logic [31:0] command_address_word_i = 32'hA0001238;
    logic [63:0] storage_data_out_bus_i = 64'h0, status_word_o, control_word_o;
    int          err_total = 0, n_checks = 0;
    ccf_channel DUT (.*);
    ccf_far_model u_far (.clk_i(clk_i), .rst_i(rst_i), .req_i(storage_request_o),
        .av_i(address_valid_o), .sel_out_i(sel_out_o), .addr_out_i(addr_out_o), .dev_i(dev),
        .ua_i(9'h105), .st_i(status), .resp_o(arb_response_i), .acc_o(arb_accept_i),
        .adv_o(arb_advance_i), .oper_o(oper_in_i), .ain_o(addr_in_i), .sin_o(sel_in_i),
        .stat_o(status_in_i), .bus_o(bus_in_i));
    always #25 clk_i = ~clk_i;
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    // One start
    task automatic run_op(input logic [7:0] cmd, input logic [15:0] cnt, input logic [2:0] dab,
                          input logic d, input logic [8:0] st, input logic er);
        int i;
        repeat (60) @(negedge clk_i);
        storage_data_out_bus_i = {cmd, 21'h0, dab, 16'h0, cnt};
        dev = d;
        status = st;
        arb_error_i = er;
        start_i = 1'b1;
        @(negedge clk_i);
        start_i = 1'b0;
        for (i = 0; i < 300 && release_o !== 1'b1; i++) @(negedge clk_i);
        if (i == 300) begin
            err_total++;
            finish_test();
        end
        dev = 1'b0;
        arb_error_i = 1'b0;
    endtask : run_op
    task automatic check_cw(input logic [1:0] op, input logic [2:0] dab, input logic [16:0] s);
        check(control_word_o[57:56], op);
        check(control_word_o[63:60], 4'hA);
        check(control_word_o[34:32], dab);
        check(control_word_o[17:0], {s[16], s});
        check(cond_code_o, 2'h0);
    endtask : check_cw
    task automatic t_write;
        run_op(8'h01, 16'h0007, 3'h5, 1'b1, 9'h100, 1'b0);
        check_cw(2'h1, 3'h5, 17'h0000C);
        check(command_required_o, 1'b0);
    endtask : t_write
    task automatic t_read;
        cu_attached_i = 1'b1;
        prefix_i = 2'h2;
        run_op(8'h02, 16'h0010, 3'h0, 1'b1, 9'h100, 1'b0);
        check_cw(2'h2, 3'h0, 17'h00010);
        check(control_word_o[26:25], 2'h2);
    endtask : t_read
    task automatic t_rdback;
        run_op(8'h0C, 16'hFFFF, 3'h2, 1'b1, 9'h100, 1'b0);
        check_cw(2'h3, 3'h5, 17'h10004);
    endtask : t_rdback
    task automatic t_nosel;
        run_op(8'h01, 16'h0020, 3'h0, 1'b0, 9'h100, 1'b0);
        check(cond_code_o, 2'h3);
    endtask : t_nosel
    task automatic t_status;
        run_op(8'h01, 16'h0020, 3'h0, 1'b1, 9'h10C, 1'b0);
        check(cond_code_o, 2'h1);
    endtask : t_status
    task automatic t_error;
        run_op(8'h02, 16'h0020, 3'h0, 1'b1, 9'h100, 1'b1);
        check(sel_check_o, 1'b1);
        check(cond_code_o, 2'h1);
    endtask : t_error
    initial begin
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        t_write();
        t_read();
        t_rdback();
        t_nosel();
        t_status();
        t_error();
        finish_test();
    end
endmodule : ccf_channel_tb
